// *** src/rlis_core.sv ***
// receive line information registers: line event monitors and readback
`timescale 1ns/1ps
module rlis_core #(
  parameter int P_E1_BITS_PER_SEC = rlis_pkg::E1_BIT_HZ,
  parameter int P_T1_BITS_PER_SEC = rlis_pkg::T1_BIT_HZ,
  parameter int P_JIT_DEPTH       = 64
) (
  // clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  // line pins
  input  wire logic       i_rclk,
  input  wire logic       i_rx_pos,
  input  wire logic       i_rx_neg,
  // configuration and neighbour logic
  input  wire logic       i_t1_mode,
  input  wire logic       i_coding_standard_select,
  input  wire logic       i_auto_loopback_enable,
  input  wire logic       i_loop_up_code,
  input  wire logic       i_loop_down_code,
  input  wire logic [7:0] i_jit_fill,
  input  wire logic [3:0] i_rx_level,
  // host port
  input  wire logic       i_rd,
  input  wire logic [7:0] i_addr,
  output logic      [7:0] o_rdata,
  output logic            o_rvalid,
  // live alarms
  output logic            o_carrier_loss_alarm,
  output logic            o_unframed_all_ones_alarm,
  output logic            o_auto_loopback_active
);
  // sizes the logic cannot serve
  if (P_JIT_DEPTH <= rlis_pkg::JIT_MARGIN || P_JIT_DEPTH > 255) begin : g_bad_depth
    $error("jitter depth out of range");
  end
  if (P_E1_BITS_PER_SEC < 2 || P_E1_BITS_PER_SEC >= (1 << 22) ||
      P_T1_BITS_PER_SEC < 2 || P_T1_BITS_PER_SEC >= (1 << 22)) begin : g_bad_sec
    $error("bits per second out of range");
  end

  localparam logic [7:0] JIT_TRIP = 8'(P_JIT_DEPTH - rlis_pkg::JIT_MARGIN);

  rlis_pkg::rlis_line_t line;            // one bit per receive clock
  rlis_line_front u_front (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_rclk     (i_rclk),
    .i_rx_pos   (i_rx_pos),
    .i_rx_neg   (i_rx_neg),
    .o_line     (line)
  );

  // line monitor state
  logic [8:0]  zrun_r,  zrun_nxt;        // zero run, saturating
  logic [7:0]  mh_r,    mh_nxt;          // mark history, newest in bit 0
  logic [7:0]  vh_r,    vh_nxt;          // violation history
  logic        lpol_r,  lpol_nxt;        // polarity of last mark
  logic        cla_r,   cla_nxt;         // carrier loss alarm
  logic        clrun_r, clrun_nxt;       // clear window open
  logic [7:0]  clcnt_r, clcnt_nxt;
  logic [7:0]  clone_r, clone_nxt;
  logic        aoa_r,   aoa_nxt;         // unframed all ones alarm
  logic [12:0] aocnt_r, aocnt_nxt;
  logic [12:0] aozer_r, aozer_nxt;
  logic [21:0] sec_r,   sec_nxt;
  // one-cycle events
  logic        ev_zr, ev_lzr, ev_cw, ev_clc, ev_aoc, ev_sec;
  logic [8:0]  zthr;
  logic [7:0]  clcnt1, clone1;
  logic [12:0] aocnt1, aozer1;
  logic        viol, hdb3, b8zs;

  // line monitors, all stepping on the bit strobe
  always_comb begin
    zrun_nxt  = zrun_r;
    mh_nxt    = mh_r;
    vh_nxt    = vh_r;
    lpol_nxt  = lpol_r;
    cla_nxt   = cla_r;
    clrun_nxt = clrun_r;
    clcnt_nxt = clcnt_r;
    clone_nxt = clone_r;
    aoa_nxt   = aoa_r;
    aocnt_nxt = aocnt_r;
    aozer_nxt = aozer_r;
    sec_nxt   = sec_r;
    ev_zr = 1'b0; ev_lzr = 1'b0; ev_cw = 1'b0;
    ev_clc = 1'b0; ev_aoc = 1'b0; ev_sec = 1'b0;
    zthr   = i_coding_standard_select ? rlis_pkg::ZR_LONG : rlis_pkg::ZR_SHORT;
    clcnt1 = clcnt_r + 8'h01;
    clone1 = clone_r + {7'h00, line.mark};
    aocnt1 = aocnt_r + 13'h0001;
    aozer1 = aozer_r + {12'h000, ~line.mark};
    viol   = line.mark & (line.pos == lpol_r);
    hdb3   = 1'b0;
    b8zs   = 1'b0;
    if (line.bit_stb) begin
      // zero runs: flag once per run at the threshold, however long it gets
      zrun_nxt = line.mark ? 9'h000 : ((zrun_r == 9'h1FF) ? zrun_r : zrun_r + 9'h001);
      ev_zr    = ~line.mark & (zrun_nxt == zthr);
      ev_lzr   = ~line.mark & (zrun_nxt == rlis_pkg::ZR_16);
      // substitution words seen regardless of decode enable
      mh_nxt   = {mh_r[6:0], line.mark};
      vh_nxt   = {vh_r[6:0], viol};
      if (line.mark) begin
        lpol_nxt = line.pos;
      end
      hdb3  = viol & (mh_r[1:0] == 2'b00);
      b8zs  = (mh_nxt[7:5] == 3'b000) & vh_nxt[4] & mh_nxt[3] & ~vh_nxt[3] &
              ~mh_nxt[2] & vh_nxt[1] & mh_nxt[0] & ~vh_nxt[0];
      ev_cw = i_coding_standard_select ? b8zs : hdb3;
      // carrier loss: set on a long zero run, clear on a window of ones
      if (!cla_r) begin
        if (zrun_nxt == (i_t1_mode ? rlis_pkg::CL_SET_T1 : rlis_pkg::CL_SET_E1)) begin
          cla_nxt   = 1'b1;
          clrun_nxt = 1'b0;
        end
      end else if (!clrun_r) begin
        // t1 window opens on the first one, e1 window at once
        if (!i_t1_mode || line.mark) begin
          clrun_nxt = 1'b1;
          clcnt_nxt = 8'h01;
          clone_nxt = {7'h00, line.mark};
        end
      end else begin
        clcnt_nxt = clcnt1;
        clone_nxt = clone1;
        if (clcnt1 == (i_t1_mode ? rlis_pkg::CL_WIN_T1 : rlis_pkg::CL_WIN_E1)) begin
          clrun_nxt = 1'b0;
          if (clone1 >= (i_t1_mode ? rlis_pkg::CL_ONES_T1 : rlis_pkg::CL_ONES_E1)) begin
            cla_nxt = 1'b0;
            ev_clc  = 1'b1;
          end
        end
      end
      // all ones: fixed windows of 512 bits or 3 ms of t1 bits
      aocnt_nxt = aocnt1;
      aozer_nxt = aozer1;
      // at or past the end, so a mode change mid-window cannot skip the close
      if (aocnt1 >= (i_t1_mode ? rlis_pkg::AO_WIN_T1 : rlis_pkg::AO_WIN_E1)) begin
        aocnt_nxt = 13'h0000;
        aozer_nxt = 13'h0000;
        if (i_t1_mode) begin
          aoa_nxt = aozer1 < rlis_pkg::AO_T1_ZMIN;
        end else if (aozer1 < rlis_pkg::AO_E1_ZMAX) begin
          aoa_nxt = 1'b1;
        end else if (aozer1 > rlis_pkg::AO_E1_ZMAX) begin
          aoa_nxt = 1'b0;
        end
        ev_aoc = aoa_r & ~aoa_nxt;
      end
      // one second from receive clock edges
      if (sec_r == (i_t1_mode ? 22'(P_T1_BITS_PER_SEC - 1) : 22'(P_E1_BITS_PER_SEC - 1))) begin
        sec_nxt = 22'h000000;
        ev_sec  = 1'b1;
      end else begin
        sec_nxt = sec_r + 22'h000001;
      end
    end
  end

  // line monitor registers
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      zrun_r <= 9'h000; mh_r <= 8'h00; vh_r <= 8'h00; lpol_r <= 1'b0;
      cla_r <= 1'b0; clrun_r <= 1'b0; clcnt_r <= 8'h00; clone_r <= 8'h00;
      aoa_r <= 1'b0; aocnt_r <= 13'h0000; aozer_r <= 13'h0000; sec_r <= 22'h000000;
    end else begin
      zrun_r <= zrun_nxt; mh_r <= mh_nxt; vh_r <= vh_nxt; lpol_r <= lpol_nxt;
      cla_r <= cla_nxt; clrun_r <= clrun_nxt; clcnt_r <= clcnt_nxt; clone_r <= clone_nxt;
      aoa_r <= aoa_nxt; aocnt_r <= aocnt_nxt; aozer_r <= aozer_nxt; sec_r <= sec_nxt;
    end
  end

  // loopback indicator and jitter trip
  rlis_pkg::rlis_lb_t lb_r, lb_nxt;
  logic [2:0]         lbs_r, lbs_nxt;    // one-second ticks seen with code present
  logic               jhi_r, jhi_nxt;
  logic               ev_jit;

  always_comb begin
    lb_nxt  = lb_r;
    lbs_nxt = lbs_r;
    jhi_nxt = i_jit_fill >= JIT_TRIP;
    ev_jit  = jhi_nxt & ~jhi_r;
    case (lb_r)
      rlis_pkg::LB_OFF: begin
        if (!i_loop_up_code) begin
          lbs_nxt = 3'h0;
        end else if (ev_sec) begin
          lbs_nxt = lbs_r + 3'h1;
          if (lbs_nxt == rlis_pkg::LB_SECS) begin
            lb_nxt  = rlis_pkg::LB_ON;
            lbs_nxt = 3'h0;
          end
        end
      end
      rlis_pkg::LB_ON: begin
        if (!i_loop_down_code) begin
          lbs_nxt = 3'h0;
        end else if (ev_sec) begin
          lbs_nxt = lbs_r + 3'h1;
          if (lbs_nxt == rlis_pkg::LB_SECS) begin
            lb_nxt  = rlis_pkg::LB_OFF;
            lbs_nxt = 3'h0;
          end
        end
      end
      default: begin
        lb_nxt  = rlis_pkg::LB_OFF;
        lbs_nxt = 3'h0;
      end
    endcase
    // disabled function forces the indicator low
    if (!i_auto_loopback_enable) begin
      lb_nxt  = rlis_pkg::LB_OFF;
      lbs_nxt = 3'h0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      lb_r  <= rlis_pkg::LB_OFF;
      lbs_r <= 3'h0;
      jhi_r <= 1'b0;
    end else begin
      lb_r  <= lb_nxt;
      lbs_r <= lbs_nxt;
      jhi_r <= jhi_nxt;
    end
  end

  // latched flags and host readback
  logic [7:0] evt_r, evt_nxt;            // event register image, low bits zero
  logic       secf_r, secf_nxt;
  logic [3:0] lvl_r;
  logic [7:0] rdata_nxt, set_mask;
  logic       rd_evt, rd_lvl;

  always_comb begin
    rd_evt   = i_rd & (i_addr == rlis_pkg::EVT_INFO_ADDR);
    rd_lvl   = i_rd & (i_addr == rlis_pkg::LVL_INFO_ADDR);
    set_mask = 8'h00;
    set_mask[rlis_pkg::ZR_BIT]  = ev_zr;
    set_mask[rlis_pkg::LZR_BIT] = ev_lzr;
    set_mask[rlis_pkg::CW_BIT]  = ev_cw;
    set_mask[rlis_pkg::CLC_BIT] = ev_clc;
    set_mask[rlis_pkg::AOC_BIT] = ev_aoc;
    set_mask[rlis_pkg::JIT_BIT] = ev_jit;
    // set wins over the read clear, so nothing is lost
    evt_nxt  = (rd_evt ? rlis_pkg::INFO_RST : evt_r) | set_mask;
    secf_nxt = (secf_r & ~rd_lvl) | ev_sec;
    // unassigned positions read as zero
    rdata_nxt = 8'h00;
    if (rd_evt) begin
      rdata_nxt = evt_r;
    end else if (rd_lvl) begin
      rdata_nxt[7:rlis_pkg::LVL_LSB] = lvl_r;
      rdata_nxt[rlis_pkg::LB_BIT]    = (lb_r == rlis_pkg::LB_ON);
      rdata_nxt[rlis_pkg::SEC_BIT]   = secf_r;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      evt_r    <= rlis_pkg::INFO_RST;
      secf_r   <= 1'b0;
      lvl_r    <= 4'h0;
      o_rdata  <= 8'h00;
      o_rvalid <= 1'b0;
      o_carrier_loss_alarm      <= 1'b0;
      o_unframed_all_ones_alarm <= 1'b0;
      o_auto_loopback_active    <= 1'b0;
    end else begin
      evt_r    <= evt_nxt;
      secf_r   <= secf_nxt;
      lvl_r    <= i_rx_level;
      o_rdata  <= rdata_nxt;
      o_rvalid <= i_rd;
      o_carrier_loss_alarm      <= cla_r;
      o_unframed_all_ones_alarm <= aoa_r;
      o_auto_loopback_active    <= (lb_r == rlis_pkg::LB_ON);
    end
  end

  // checks
  property p_zr;
    @(posedge i_core_clk) disable iff (i_rst) ev_zr |=> evt_r[rlis_pkg::ZR_BIT];
  endproperty
  a_zr: assert property (p_zr) else $error("zero run not latched");
  property p_lzr;
    @(posedge i_core_clk) disable iff (i_rst)
      line.bit_stb && !line.mark && zrun_r == 9'h00F |=> evt_r[rlis_pkg::LZR_BIT];
  endproperty
  a_lzr: assert property (p_lzr) else $error("16 zeros not latched");
  property p_cw;
    @(posedge i_core_clk) disable iff (i_rst)
      line.bit_stb && !i_coding_standard_select && hdb3 |=> evt_r[rlis_pkg::CW_BIT];
  endproperty
  a_cw: assert property (p_cw) else $error("code word not latched");
  property p_clc;
    @(posedge i_core_clk) disable iff (i_rst) $fell(cla_r) |-> evt_r[rlis_pkg::CLC_BIT];
  endproperty
  a_clc: assert property (p_clc) else $error("carrier clear not latched");
  property p_aoc;
    @(posedge i_core_clk) disable iff (i_rst) $fell(aoa_r) |-> evt_r[rlis_pkg::AOC_BIT];
  endproperty
  a_aoc: assert property (p_aoc) else $error("all ones clear not latched");
  property p_jit;
    @(posedge i_core_clk) disable iff (i_rst)
      $rose(jhi_r) |-> evt_r[rlis_pkg::JIT_BIT];
  endproperty
  a_jit: assert property (p_jit) else $error("jitter trip not latched");
  property p_lbon;
    @(posedge i_core_clk) disable iff (i_rst)
      $rose(lb_r == rlis_pkg::LB_ON) |-> $past(i_loop_up_code) && $past(ev_sec);
  endproperty
  a_lbon: assert property (p_lbon) else $error("loopback set without up code");
  property p_lboff;
    @(posedge i_core_clk) disable iff (i_rst)
      !i_auto_loopback_enable |=> ##1 !o_auto_loopback_active;
  endproperty
  a_lboff: assert property (p_lboff) else $error("loopback shown while disabled");
  property p_keep;
    @(posedge i_core_clk) disable iff (i_rst)
      rd_evt && ev_zr |=> evt_r[rlis_pkg::ZR_BIT];
  endproperty
  a_keep: assert property (p_keep) else $error("event lost in read cycle");
  property p_sec;
    @(posedge i_core_clk) disable iff (i_rst) ev_sec |=> secf_r;
  endproperty
  a_sec: assert property (p_sec) else $error("second tick not latched");
  c_clear: cover property (@(posedge i_core_clk) disable iff (i_rst) $fell(cla_r));
  c_lb:    cover property (@(posedge i_core_clk) disable iff (i_rst) $rose(o_auto_loopback_active));
  c_race:  cover property (@(posedge i_core_clk) disable iff (i_rst) rd_evt && |set_mask);
endmodule

// *** src/rlis_line_front.sv ***
// line pin sampler: receive clock edge and bipolar data to bit strobes
`timescale 1ns/1ps
module rlis_line_front (
  // clock and reset
  input  wire logic               i_core_clk,
  input  wire logic               i_rst,
  // line pins
  input  wire logic               i_rclk,
  input  wire logic               i_rx_pos,
  input  wire logic               i_rx_neg,
  // sampled bits
  output rlis_pkg::rlis_line_t    o_line
);
  logic [2:0]           s1_r;     // first stage, read only by s2
  logic [2:0]           s2_r;
  logic [2:0]           s3_r;
  logic [2:0]           filt_r;   // {clk,pos,neg} after agreement
  logic [2:0]           filt_nxt;
  rlis_pkg::rlis_line_t line_r;
  rlis_pkg::rlis_line_t line_nxt;

  // a bit changes only once stages two and three agree
  always_comb begin
    filt_nxt          = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & filt_r);
    line_nxt.bit_stb  = filt_nxt[2] & ~filt_r[2];
    line_nxt.mark     = filt_nxt[1] | filt_nxt[0];
    line_nxt.pos      = filt_nxt[1];
  end

  // registers only; data and clock share one delay so they stay aligned
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      s1_r   <= 3'h0;
      s2_r   <= 3'h0;
      s3_r   <= 3'h0;
      filt_r <= 3'h0;
      line_r <= '0;
    end else begin
      s1_r   <= {i_rclk, i_rx_pos, i_rx_neg};
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      filt_r <= filt_nxt;
      line_r <= line_nxt;
    end
  end

  assign o_line = line_r;
endmodule

// *** src/rlis_pkg.sv ***
// constants and types for the receive line information registers
package rlis_pkg;
  // register addresses on the host port and the event register reset value
  localparam logic [7:0] EVT_INFO_ADDR = 8'h08;
  localparam logic [7:0] LVL_INFO_ADDR = 8'h09;
  localparam logic [7:0] INFO_RST      = 8'h00;
  // field positions
  localparam int ZR_BIT  = 7;
  localparam int LZR_BIT = 6;
  localparam int CW_BIT  = 5;
  localparam int CLC_BIT = 4;
  localparam int AOC_BIT = 3;
  localparam int JIT_BIT = 2;
  localparam int LVL_LSB = 4;
  localparam int LB_BIT  = 1;
  localparam int SEC_BIT = 0;
  // zero run thresholds, in line bits
  localparam logic [8:0] ZR_SHORT  = 9'h004;
  localparam logic [8:0] ZR_LONG   = 9'h008;
  localparam logic [8:0] ZR_16     = 9'h010;
  localparam logic [8:0] CL_SET_E1 = 9'h0FF;
  localparam logic [8:0] CL_SET_T1 = 9'h0C0;
  // carrier loss clear windows
  localparam logic [7:0] CL_WIN_E1  = 8'hFF;
  localparam logic [7:0] CL_ONES_E1 = 8'h20;
  localparam logic [7:0] CL_WIN_T1  = 8'h70;
  localparam logic [7:0] CL_ONES_T1 = 8'h0E;
  // line rates and the all-ones windows
  localparam int          E1_BIT_HZ  = 2048000;
  localparam int          T1_BIT_HZ  = 1544000;
  localparam int          AO_T1_MS   = 3;
  localparam logic [12:0] AO_WIN_E1  = 13'h0200;
  localparam logic [12:0] AO_WIN_T1  = 13'(T1_BIT_HZ * AO_T1_MS / 1000);
  localparam logic [12:0] AO_E1_ZMAX = 13'h0002;
  localparam logic [12:0] AO_T1_ZMIN = 13'h0006;
  // jitter margin and loopback persistence
  localparam int         JIT_MARGIN = 4;
  localparam logic [2:0] LB_SECS    = 3'h5;
  // one sampled line bit
  typedef struct packed {
    logic bit_stb;
    logic mark;
    logic pos;
  } rlis_line_t;
  // loopback indicator states
  typedef enum logic {LB_OFF, LB_ON} rlis_lb_t;
endpackage

// *** tb/rlis_core_tb.sv ***
// self-checking bench for the receive line information registers
`timescale 1ns/1ps
module rlis_core_tb;
  localparam int P_BITS = 20; // line bits per simulated second

  logic       i_core_clk;
  logic       i_rst;
  logic       rclk;
  logic       pos;
  logic       neg;
  logic       t1_mode;
  logic       sel;
  logic       lb_en;
  logic       up;
  logic       dn;
  logic       rd_stb;
  logic [7:0] jit;
  logic [7:0] addr;
  logic [3:0] lvl;
  logic [7:0] rdata;
  logic       rvalid;
  logic       cl_alarm;
  logic       ao_alarm;
  logic       lb_act;
  logic [7:0] got;
  int         fails;
  int         n_tests;
  // zero run table: select, run length, expected top two flags
  logic       zsel [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
  int         zn   [6] = '{3, 4, 7, 8, 15, 16};
  logic [7:0] zexp [6] = '{8'h00, 8'h80, 8'h00, 8'h80, 8'h80, 8'hC0};

  rlis_core #(.P_E1_BITS_PER_SEC(P_BITS), .P_T1_BITS_PER_SEC(P_BITS)) i_rlis_core (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_rclk(rclk), .i_rx_pos(pos), .i_rx_neg(neg),
    .i_t1_mode(t1_mode), .i_coding_standard_select(sel), .i_auto_loopback_enable(lb_en),
    .i_loop_up_code(up), .i_loop_down_code(dn), .i_jit_fill(jit), .i_rx_level(lvl),
    .i_rd(rd_stb), .i_addr(addr), .o_rdata(rdata), .o_rvalid(rvalid),
    .o_carrier_loss_alarm(cl_alarm), .o_unframed_all_ones_alarm(ao_alarm),
    .o_auto_loopback_active(lb_act));

  rlis_line_model i_rlis_line_model (
    .i_core_clk(i_core_clk), .o_rclk(rclk), .o_pos(pos), .o_neg(neg));

  // verdict and end of run, the only exit
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // compare one byte
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // one host read; jraise lifts the fifo fill in the same cycle as the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d, input logic jraise = 1'b0);
    int k;
    @(negedge i_core_clk);
    rd_stb = 1'b1;
    addr   = a;
    if (jraise) begin
      jit = 8'h3C;
    end
    @(negedge i_core_clk);
    rd_stb = 1'b0;
    k = 0;
    // answer is due one cycle later; a short bound catches a dead port
    while (rvalid !== 1'b1 && k < 4) begin
      @(negedge i_core_clk);
      k++;
    end
    if (k == 4) begin
      fails++;
      final_report();
    end
    d = rdata;
  endtask

  // read and compare under a mask, so unassigned bits are never judged
  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    rd(a, got);
    check(got & m, e);
  endtask

  // let a line bit pass the synchroniser and land in the flags
  task automatic settle();
    repeat (12) @(negedge i_core_clk);
  endtask

  // 200 MHz core clock
  initial begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end

  // watchdog against a hang anywhere
  initial begin
    repeat (95000) @(posedge i_core_clk);
    fails++;
    final_report();
  end

  initial begin
    fails   = 0;
    n_tests = 0;
    i_rst   = 1'b1;
    t1_mode = 1'b0;
    sel     = 1'b0;
    lb_en   = 1'b0;
    up      = 1'b0;
    dn      = 1'b0;
    rd_stb  = 1'b0;
    addr    = 8'h00;
    jit     = 8'h00;
    lvl     = 4'h0;
    repeat (10) @(negedge i_core_clk);
    i_rst = 1'b0;
    // reset state, unmapped address answers zero
    rchk(8'h08, 8'hFC, 8'h00);
    rchk(8'h09, 8'hF3, 8'h00);
    rchk(8'h0A, 8'hFF, 8'h00);
    // every level code shows live in the top nibble
    for (int i = 0; i < 16; i++) begin
      lvl = 4'(i);
      repeat (3) @(negedge i_core_clk);
      rchk(8'h09, 8'hF0, {4'(i), 4'h0});
    end
    // zero runs at and around each threshold, then cleared by the read
    for (int i = 0; i < 6; i++) begin
      sel = zsel[i];
      i_rlis_line_model.send(1'b1, 1'b0);
      settle();
      rd(8'h08, got);
      i_rlis_line_model.run(zn[i], 1'b0);
      i_rlis_line_model.send(1'b1, 1'b0);
      settle();
      rchk(8'h08, 8'hC0, zexp[i]);
      rchk(8'h08, 8'hC0, 8'h00);
    end
    // substitution word: violation after two zeros
    sel = 1'b0;
    rd(8'h08, got);
    i_rlis_line_model.send(1'b1, 1'b0);
    i_rlis_line_model.run(2, 1'b0);
    i_rlis_line_model.send(1'b1, 1'b1);
    settle();
    rchk(8'h08, 8'h20, 8'h20);
    // substitution word 000VB0VB with the other select
    sel = 1'b1;
    rd(8'h08, got);
    i_rlis_line_model.send(1'b1, 1'b0);
    i_rlis_line_model.run(3, 1'b0);
    i_rlis_line_model.send(1'b1, 1'b1);
    i_rlis_line_model.send(1'b1, 1'b0);
    i_rlis_line_model.send(1'b0, 1'b0);
    i_rlis_line_model.send(1'b1, 1'b1);
    i_rlis_line_model.send(1'b1, 1'b0);
    settle();
    rchk(8'h08, 8'h20, 8'h20);
    // fifo fill one short of the trip, at the trip, then cleared
    jit = 8'h3B;
    settle();
    rchk(8'h08, 8'h04, 8'h00);
    jit = 8'h3C;
    settle();
    rchk(8'h08, 8'h04, 8'h04);
    rchk(8'h08, 8'h04, 8'h00);
    // trip arriving with the read strobe must survive that read
    jit = 8'h00;
    settle();
    rd(8'h08, got, 1'b1);
    rchk(8'h08, 8'h04, 8'h04);
    // e1 carrier loss: failed window keeps the alarm, full window clears it
    i_rlis_line_model.run(255, 1'b0);
    settle();
    check({7'h00, cl_alarm}, 8'h01);
    i_rlis_line_model.run(31, 1'b1);
    i_rlis_line_model.run(224, 1'b0);
    settle();
    check({7'h00, cl_alarm}, 8'h01);
    rchk(8'h08, 8'h10, 8'h00);
    i_rlis_line_model.run(255, 1'b1);
    settle();
    check({7'h00, cl_alarm}, 8'h00);
    rchk(8'h08, 8'h10, 8'h10);
    // t1 carrier loss: 13 ones fail, 14 ones clear
    t1_mode = 1'b1;
    i_rlis_line_model.run(192, 1'b0);
    i_rlis_line_model.run(13, 1'b1);
    i_rlis_line_model.run(99, 1'b0);
    settle();
    check({7'h00, cl_alarm}, 8'h01);
    rchk(8'h08, 8'h10, 8'h00);
    i_rlis_line_model.run(14, 1'b1);
    i_rlis_line_model.run(98, 1'b0);
    settle();
    check({7'h00, cl_alarm}, 8'h00);
    rchk(8'h08, 8'h10, 8'h10);
    // e1 all ones sets, then a zero every hundred bits clears it
    t1_mode = 1'b0;
    i_rlis_line_model.run(1536, 1'b1);
    settle();
    check({7'h00, ao_alarm}, 8'h01);
    rchk(8'h08, 8'h08, 8'h00);
    for (int i = 0; i < 11; i++) begin
      i_rlis_line_model.run(99, 1'b1);
      i_rlis_line_model.send(1'b0, 1'b0);
    end
    settle();
    check({7'h00, ao_alarm}, 8'h00);
    rchk(8'h08, 8'h08, 8'h08);
    // one second of line bits sets the tick, the read clears it
    rd(8'h09, got);
    i_rlis_line_model.run(P_BITS, 1'b1);
    settle();
    rchk(8'h09, 8'h01, 8'h01);
    rchk(8'h09, 8'h01, 8'h00);
    // loopback needs five one-second ticks with each code present
    lb_en = 1'b1;
    up    = 1'b1;
    i_rlis_line_model.run(4 * P_BITS, 1'b1);
    settle();
    check({7'h00, lb_act}, 8'h00);
    i_rlis_line_model.run(2 * P_BITS, 1'b1);
    settle();
    rchk(8'h09, 8'h02, 8'h02);
    up = 1'b0;
    dn = 1'b1;
    i_rlis_line_model.run(4 * P_BITS, 1'b1);
    settle();
    check({7'h00, lb_act}, 8'h01);
    i_rlis_line_model.run(2 * P_BITS, 1'b1);
    settle();
    rchk(8'h09, 8'h02, 8'h00);
    // disable forces the indicator low within three cycles
    up = 1'b1;
    dn = 1'b0;
    i_rlis_line_model.run(6 * P_BITS, 1'b1);
    settle();
    check({7'h00, lb_act}, 8'h01);
    lb_en = 1'b0;
    repeat (3) @(negedge i_core_clk);
    check({7'h00, lb_act}, 8'h00);
    rchk(8'h09, 8'h02, 8'h00);
    final_report();
  end
endmodule

// *** tb/rlis_line_model.sv ***
// remote line transmitter model: bipolar marks under a gated line clock
`timescale 1ns/1ps
module rlis_line_model (
  // pacing clock
  input  wire logic i_core_clk,
  // line pins toward the block
  output logic      o_rclk,
  output logic      o_pos,
  output logic      o_neg
);
  logic last_pos; // polarity of the previous mark

  // idle line: clock parked low, no marks
  initial begin
    o_rclk   = 1'b0;
    o_pos    = 1'b0;
    o_neg    = 1'b0;
    last_pos = 1'b0;
  end

  // one bit: data moves while clock is low, so it is steady at the rising edge
  // a violation repeats the last polarity, a normal mark alternates
  task automatic send(input logic one, input logic viol);
    logic p;
    p = viol ? last_pos : ~last_pos;
    @(negedge i_core_clk);
    o_pos = one & p;
    o_neg = one & ~p;
    if (one) begin
      last_pos = p;
    end
    // low and high phases both well above the two cycle minimum
    repeat (4) @(negedge i_core_clk);
    o_rclk = 1'b1;
    repeat (4) @(negedge i_core_clk);
    o_rclk = 1'b0;
  endtask

  // a run of plain bits; clock stands still after the last one
  task automatic run(input int n, input logic one);
    repeat (n) send(one, 1'b0);
  endtask
endmodule
